// >>> src/adc_seq_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz system clock and a 512 kHz conversion oscillator
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
`define CFG_ADDR 4'h0
`define RES_ADDR 4'h4
`define STAT_ADDR 4'h8
`define LSB_ADDR 4'hc
`define CFG_START_BIT 15
`define CFG_SEL_MSB 14
`define CFG_SEL_LSB 12
`define CFG_FSS_MSB 11
`define CFG_FSS_LSB 9
`define CFG_MODE_BIT 8
`define CFG_RATE_MSB 7
`define CFG_RATE_LSB 5
`define CFG_REF_BIT 1
`define SEL_RST 3'h0
`define FSS_RST 3'h2
`define RATE_RST 3'h4
`define MODE_RST 1'b1
`define REF_RST 1'b0
`define RES_RST 16'h0000
`define CLK_KHZ 40000
`define OSC_KHZ 512
`define CLK_PERIOD_NS 25
`define PWRUP_NS 25000
`define PWRUP_CYCLES ((`PWRUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READY_LEAD_NS 8000
`define READY_LEAD_TICKS ((`READY_LEAD_NS * `OSC_KHZ) / 1000000)
`define PER_6P25 17'd81920
`define PER_12P5 17'd40960
`define PER_25 17'd20480
`define PER_50 17'd10240
`define PER_100 17'd5120
`define PER_250 17'd2048
`define PER_500 17'd1024
`define PER_1000 17'd512
`define POS_CLAMP 16'h7fff
`define NEG_CLAMP 16'h8000
`endif

// >>> src/adc_seq_pkg.sv
// types shared by the conversion sequencer files
package adc_seq_pkg;
  typedef enum logic [2:0] {
    ST_DOWN = 3'b001,
    ST_WAKE = 3'b010,
    ST_CONV = 3'b100
  } seq_state_t;
  typedef logic [2:0] field3_t;
  typedef logic [15:0] code_t;
endpackage

// >>> src/osc_tick.sv
// fractional divider: one-cycle tick at the oscillator rate
// assumes step is below modulus so at most one tick per clock
`timescale 1ns/1ps
module osc_tick #(
  parameter int STEP = 512,
  parameter int MODULUS = 40000,
  parameter int AW = 17
)(
  input wire logic clk_sys,
  input wire logic rstn,
  output logic tick
);
  logic [AW-1:0] acc_r;
  logic [AW-1:0] sum;

  initial
  begin
    if (STEP < 1 || STEP >= MODULUS || MODULUS >= (1 << (AW - 1)))
      $error("osc_tick: step or modulus out of range");
  end

  assign sum = acc_r + AW'(STEP);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_r <= '0;
      tick <= 1'b0;
    end
    else if (sum >= AW'(MODULUS))
    begin
      acc_r <= sum - AW'(MODULUS);
      tick <= 1'b1;
    end
    else
    begin
      acc_r <= sum;
      tick <= 1'b0;
    end
  end
endmodule

// >>> src/result_clamp.sv
// saturates the filter output to a 16-bit two's complement code
// assumes the filter word is already scaled so that 2^15 is full scale
`timescale 1ns/1ps
module result_clamp
  import adc_seq_pkg::*;
#(
  parameter int IW = 20
)(
  input wire logic signed [IW-1:0] raw,
  input wire logic single_ended,
  output code_t code
);
  `include "adc_seq_regs.svh"
  localparam logic signed [IW-1:0] MAXV = IW'(32767);
  localparam logic signed [IW-1:0] MINV = -IW'(32768);

  initial
  begin
    if (IW < 16)
      $error("result_clamp: filter word narrower than result");
  end

  always_comb
  begin
    if (single_ended && raw < 0)
      code = 16'h0000;
    else if (raw >= MAXV)
      code = `POS_CLAMP;
    else if (raw <= MINV)
      code = `NEG_CLAMP;
    else
      code = raw[15:0];
  end
endmodule

// >>> src/adc_conversion_sequencer.sv
// conversion sequencer of a 16-bit delta-sigma converter
// assumes the filter word is valid on clk_sys at the end of a conversion
// and that software reaches the registers over the plain port below
//
// How it works
// - single-shot: one conversion, store, power down
// - continuous: restart right after each completion
// - input_select picks one of eight input pairs
// - single-ended: negative leg grounded, no negatives
// - full_scale_select picks one of seven ranges
// - step weight is span over 2^16
// - timing from internal 512 kHz oscillator
// - rate_select picks one of eight rates
// - conversion lasts one output period
// - reset loads defaults, powered down, idle
// - mode 1 means single-shot, powered down
// - writes still act while powered down
// - start_single: wake 25 us, clear, convert
// - start_single ignored while converting
// - mode 0 enters continuous conversion
// - new settings wait for next conversion
// - mode 1 or reset leaves continuous
// - result register holds latest result
// - analog_in_3 may serve as reference
// - serial_out_ready goes low on new result
// - results clamp to 7fff and 8000
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int FILT_W = 20,
  parameter int OSC_STEP_KHZ = `OSC_KHZ,
  parameter int CLK_RATE_KHZ = `CLK_KHZ,
  parameter int WAKE_CYCLES = `PWRUP_CYCLES
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [FILT_W-1:0] filter_data,
  output logic [1:0] mux_pos,
  output logic [1:0] mux_neg,
  output logic mux_neg_gnd,
  output logic [2:0] full_scale_select,
  output logic ref_ext_sel,
  output logic modulator_on,
  output logic filter_restart,
  output logic serial_out_ready,
  output logic conv_busy
);

  initial
  begin
    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535)
      $error("adc_conversion_sequencer: wake count out of range");
  end

  // software-visible configuration, may change at any time
  logic start_req_r;
  field3_t input_select_r;
  field3_t fss_r;
  logic mode_r;
  field3_t rate_select_r;
  logic ref_r;

  // settings in force for the running conversion
  field3_t act_sel_r;
  field3_t act_fss_r;
  field3_t act_rate_r;
  logic act_ref_r;

  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [15:0] wake_cnt_r;
  logic [16:0] tick_cnt_r;
  logic [16:0] period;
  logic osc_tick_s;
  logic conv_done;
  logic begin_conv;
  logic single_ended;
  code_t clamped;
  code_t result_r;
  logic data_new_r;
  logic lead_drop;
  logic cfg_wr;
  logic res_rd;
  logic [31:0] rdata_nxt;

  assign cfg_wr = reg_wr && (reg_addr == `CFG_ADDR);
  assign res_rd = reg_rd && (reg_addr == `RES_ADDR);

  osc_tick #(
    .STEP(OSC_STEP_KHZ),
    .MODULUS(CLK_RATE_KHZ),
    .AW(17)
  ) u_osc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(osc_tick_s)
  );

  // oscillator cycles per conversion for each rate code
  function automatic logic [16:0] rate_period(input field3_t r);
    logic [16:0] p;
    p = `PER_1000;
    unique case (r)
      3'h0: p = `PER_6P25;
      3'h1: p = `PER_12P5;
      3'h2: p = `PER_25;
      3'h3: p = `PER_50;
      3'h4: p = `PER_100;
      3'h5: p = `PER_250;
      3'h6: p = `PER_500;
      3'h7: p = `PER_1000;
    endcase
    return p;
  endfunction

  // step weight in picovolts: span over 2^16
  function automatic logic [31:0] lsb_weight_pv(input field3_t f);
    logic [31:0] w;
    w = 32'h0;
    unique case (f)
      3'h0: w = 32'd187500000;
      3'h1: w = 32'd125000000;
      3'h2: w = 32'd62500000;
      3'h3: w = 32'd31250000;
      3'h4: w = 32'd15625000;
      3'h5: w = 32'd7812500;
      3'h6: w = 32'd1953125;
      3'h7: w = 32'd1953125;
    endcase
    return w;
  endfunction

  assign period = rate_period(act_rate_r);

  // configuration register; a write acts even while powered down
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      input_select_r <= `SEL_RST;
      fss_r <= `FSS_RST;
      mode_r <= `MODE_RST;
      rate_select_r <= `RATE_RST;
      ref_r <= `REF_RST;
    end
    else if (cfg_wr)
    begin
      input_select_r <= reg_wdata[`CFG_SEL_MSB:`CFG_SEL_LSB];
      fss_r <= reg_wdata[`CFG_FSS_MSB:`CFG_FSS_LSB];
      mode_r <= reg_wdata[`CFG_MODE_BIT];
      rate_select_r <= reg_wdata[`CFG_RATE_MSB:`CFG_RATE_LSB];
      ref_r <= reg_wdata[`CFG_REF_BIT];
    end
  end

  // start request: taken only when single-shot and idle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      start_req_r <= 1'b0;
    else if (state_r == ST_WAKE && wake_cnt_r == 16'h0)
      start_req_r <= 1'b0;
    else if (cfg_wr && reg_wdata[`CFG_START_BIT] &&
             reg_wdata[`CFG_MODE_BIT] && state_r == ST_DOWN)
      start_req_r <= 1'b1;
    else if (cfg_wr && !reg_wdata[`CFG_MODE_BIT])
      start_req_r <= 1'b0;
  end

  assign conv_done = (state_r == ST_CONV) && osc_tick_s &&
                     (tick_cnt_r == period - 17'd1);
  assign begin_conv = (state_r == ST_WAKE && wake_cnt_r == 16'h0) ||
                      (conv_done && !mode_r);

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_DOWN:
      begin
        if (start_req_r || !mode_r)
          state_nxt = ST_WAKE;
      end
      ST_WAKE:
      begin
        if (wake_cnt_r == 16'h0)
          state_nxt = ST_CONV;
      end
      ST_CONV:
      begin
        if (conv_done && mode_r)
          state_nxt = ST_DOWN;
      end
      default: state_nxt = ST_DOWN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      state_r <= ST_DOWN;
    else
      state_r <= state_nxt;
  end

  // power-up wait before the first conversion after idle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      wake_cnt_r <= 16'h0;
    else if (state_r == ST_DOWN)
      wake_cnt_r <= 16'(WAKE_CYCLES - 1);
    else if (state_r == ST_WAKE && wake_cnt_r != 16'h0)
      wake_cnt_r <= wake_cnt_r - 16'h1;
  end

  // oscillator-cycle count within the running conversion
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      tick_cnt_r <= 17'h0;
    else if (begin_conv || state_r != ST_CONV)
      tick_cnt_r <= 17'h0;
    else if (osc_tick_s)
      tick_cnt_r <= tick_cnt_r + 17'h1;
  end

  // settings are adopted only at a conversion boundary
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      act_sel_r <= `SEL_RST;
      act_fss_r <= `FSS_RST;
      act_rate_r <= `RATE_RST;
      act_ref_r <= `REF_RST;
    end
    else if (begin_conv)
    begin
      act_sel_r <= input_select_r;
      act_fss_r <= fss_r;
      act_rate_r <= rate_select_r;
      act_ref_r <= ref_r;
    end
  end

  // analog steering: codes 4..7 measure against ground
  assign single_ended = act_sel_r[2];

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mux_pos <= 2'h0;
      mux_neg <= 2'h1;
      mux_neg_gnd <= 1'b0;
    end
    else
    begin
      mux_neg_gnd <= single_ended;
      // pairs 0-1, 0-3, 1-3, 2-3; codes 4..7 take their input against ground
      if (single_ended)
      begin
        mux_pos <= act_sel_r[1:0];
        mux_neg <= 2'h0;
      end
      else if (act_sel_r[1:0] == 2'h0)
      begin
        mux_pos <= 2'h0;
        mux_neg <= 2'h1;
      end
      else
      begin
        mux_pos <= act_sel_r[1:0] - 2'h1;
        mux_neg <= 2'h3;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      full_scale_select <= `FSS_RST;
      ref_ext_sel <= `REF_RST;
      modulator_on <= 1'b0;
      filter_restart <= 1'b0;
      conv_busy <= 1'b0;
    end
    else
    begin
      full_scale_select <= act_fss_r;
      ref_ext_sel <= act_ref_r;
      modulator_on <= (state_nxt != ST_DOWN);
      filter_restart <= begin_conv;
      conv_busy <= (state_nxt == ST_CONV);
    end
  end

  result_clamp #(
    .IW(FILT_W)
  ) u_clamp (
    .raw(filter_data),
    .single_ended(single_ended),
    .code(clamped)
  );

  // result holds the last completed conversion until replaced
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      result_r <= `RES_RST;
    else if (conv_done)
      result_r <= clamped;
  end

  // ready flag: a completion beats a read in the same cycle;
  // in continuous mode, unread data is withdrawn shortly before the next completion
  assign lead_drop = (state_r == ST_CONV) && !mode_r &&
                     (tick_cnt_r >= period - 17'(`READY_LEAD_TICKS));

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      data_new_r <= 1'b0;
    else if (conv_done)
      data_new_r <= 1'b1;
    else if (res_rd || lead_drop)
      data_new_r <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      serial_out_ready <= 1'b1;
    else
      serial_out_ready <= !(conv_done || (data_new_r && !res_rd && !lead_drop));
  end

  // register read, data one cycle after the strobe
  always_comb
  begin
    rdata_nxt = 32'h0;
    unique case (reg_addr)
      `CFG_ADDR:
      begin
        rdata_nxt[`CFG_START_BIT] = start_req_r;
        rdata_nxt[`CFG_SEL_MSB:`CFG_SEL_LSB] = input_select_r;
        rdata_nxt[`CFG_FSS_MSB:`CFG_FSS_LSB] = fss_r;
        rdata_nxt[`CFG_MODE_BIT] = mode_r;
        rdata_nxt[`CFG_RATE_MSB:`CFG_RATE_LSB] = rate_select_r;
        rdata_nxt[`CFG_REF_BIT] = ref_r;
      end
      `RES_ADDR: rdata_nxt = {16'h0, result_r};
      `STAT_ADDR: rdata_nxt = {28'h0, !mode_r, data_new_r,
                               state_r == ST_CONV, state_r != ST_DOWN};
      `LSB_ADDR: rdata_nxt = lsb_weight_pv(act_fss_r);
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rdata_nxt : 32'h0;
  end
endmodule

// >>> sim/seq_monitor.sv
// concurrent checks on the sequencer's ports
// assumes bind from the bench; one clock domain, async active-low reset
`timescale 1ns/1ps
`include "adc_seq_regs.svh"
module seq_monitor #(
  parameter int WAKE_CYCLES = 10
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] mux_neg,
  input wire logic mux_neg_gnd,
  input wire logic modulator_on,
  input wire logic filter_restart,
  input wire logic serial_out_ready,
  input wire logic conv_busy
);
  int wake_cnt_r;
  // cycles powered but not yet converting
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      wake_cnt_r <= 0;
    else if (modulator_on && !conv_busy)
      wake_cnt_r <= wake_cnt_r + 1;
    else
      wake_cnt_r <= 0;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  AST_READY_DROP: assert property ($fell(serial_out_ready) |-> $past(conv_busy))
    else $error("ready fell without a completed conversion");
  AST_READY_HOLD: assert property ($rose(serial_out_ready) && !modulator_on |->
    ($past(reg_rd) && $past(reg_addr) == `RES_ADDR) ||
    ($past(reg_rd, 2) && $past(reg_addr, 2) == `RES_ADDR))
    else $error("ready withdrawn without a result read");
  AST_RESTART_PULSE: assert property (filter_restart |=> !filter_restart)
    else $error("filter restart longer than one cycle");
  AST_RESTART_CAUSE: assert property ($rose(conv_busy) |-> ##[0:1] filter_restart)
    else $error("conversion began without filter restart");
  AST_BUSY_POWER: assert property (conv_busy |-> modulator_on)
    else $error("converting while powered down");
  AST_GND_LEG: assert property (mux_neg_gnd |-> mux_neg == 2'h0)
    else $error("grounded leg with a negative input selected");
  AST_WAKE_LEN: assert property ($rose(conv_busy) && wake_cnt_r > 2 |->
    wake_cnt_r == WAKE_CYCLES)
    else $error("wake time wrong");
  cover property ($fell(serial_out_ready));
  cover property ($rose(conv_busy));
  cover property (mux_neg_gnd && conv_busy);
endmodule

// >>> sim/filter_model.sv
// stand-in for modulator and filter: drives the filter word
// assumes the bench sets level; unpowered word toggles, never holds
`timescale 1ns/1ps
module filter_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic modulator_on,
  input wire logic signed [19:0] level,
  output logic signed [19:0] filter_data
);
  logic signed [19:0] junk_r;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      junk_r <= 20'h5a5a5;
    else
      junk_r <= ~junk_r;
  end
  assign filter_data = modulator_on ? level : junk_r;
endmodule

// >>> sim/adc_conversion_sequencer_test.sv
// self-checking bench for the conversion sequencer
// assumes fast oscillator ticks (one per two clocks) and a short wake
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
  localparam int WAKE = 10;
  localparam logic [31:0] LSB_PV [8] = '{32'hb2d05e0, 32'h7735940, 32'h3b9aca0,
    32'h1dcd650, 32'hee6b28, 32'h773594, 32'h1dcd65, 32'h1dcd65};
  localparam logic [4:0] MUX_EXP [8] = '{5'h02, 5'h06, 5'h0e, 5'h16,
    5'h01, 5'h09, 5'h11, 5'h19};
  logic clk_sys, rstn, reg_wr, reg_rd, mux_neg_gnd, ref_ext_sel;
  logic modulator_on, filter_restart, serial_out_ready, conv_busy;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [31:0] reg_rdata, d;
  logic signed [19:0] filter_data, level;
  logic [1:0] mux_pos, mux_neg;
  logic [2:0] full_scale_select;
  int n_fail, compares, cyc, n;
  adc_conversion_sequencer #(.OSC_STEP_KHZ(20000), .WAKE_CYCLES(WAKE))
    adc_conversion_sequencer_i (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .filter_data(filter_data), .mux_pos(mux_pos), .mux_neg(mux_neg),
    .mux_neg_gnd(mux_neg_gnd), .full_scale_select(full_scale_select),
    .ref_ext_sel(ref_ext_sel), .modulator_on(modulator_on),
    .filter_restart(filter_restart), .serial_out_ready(serial_out_ready),
    .conv_busy(conv_busy));
  filter_model filter_model_i (.clk_sys(clk_sys), .rstn(rstn),
    .modulator_on(modulator_on), .level(level), .filter_data(filter_data));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // which 1 waits on conv_busy, 0 on serial_out_ready; n holds cycles spent
  task automatic wait_sig(input int which, input logic val);
    for (n = 0; n < 3000 && ((which ? conv_busy : serial_out_ready) !== val); n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk("wait bound", 32'h1, 32'(n < 3000));
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 25000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  initial
  begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, level, cyc} = '0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(4'h0, d);
    chk("cfg reset", 32'h580, d);
    chk("power reset", 32'h0, 32'(modulator_on));
    wr(4'h4, 16'hffff);
    rd(4'h4, d);
    chk("result ro", 32'h0, d);
    rd(4'h2, d);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 8; i++)
    begin
      // idle writes reach the analog side only when the started conversion adopts them
      wr(4'h0, {1'b1, 3'(i), 3'(i), 1'b1, 3'h7, 3'h0, i[0], 1'b0});
      wait_sig(1, 1'b1);
      @(posedge clk_sys);
      #1;
      chk("mux", 32'(MUX_EXP[i]), 32'({mux_pos, mux_neg, mux_neg_gnd}));
      chk("fss", 32'(i), 32'(full_scale_select));
      chk("ref", 32'(i[0]), 32'(ref_ext_sel));
      rd(4'hc, d);
      chk("lsb", LSB_PV[i], d);
      wait_sig(1, 1'b0);
    end
    level <= -20'sd100;
    wr(4'h0, 16'hcfe0);
    @(posedge clk_sys);
    #1;
    chk("wake power", 32'h1, 32'(modulator_on));
    wait_sig(1, 1'b1);
    wr(4'h0, 16'hcfe0);
    wait_sig(1, 1'b0);
    chk("conv length", 32'h1, 32'(n + 2 >= 1023 && n + 2 <= 1025));
    repeat (20) @(posedge clk_sys);
    #1;
    chk("single done", 32'h0, 32'({modulator_on, conv_busy, serial_out_ready}));
    rd(4'h0, d);
    chk("start cleared", 32'h4fe0, d);
    rd(4'h4, d);
    chk("single-ended", 32'h0, d);
    @(posedge clk_sys);
    #1;
    chk("ready read", 32'h1, 32'(serial_out_ready));
    level <= 20'sd40000;
    wr(4'h0, 16'h04e0);
    wait_sig(0, 1'b0);
    rd(4'h4, d);
    chk("pos clamp", 32'h7fff, d);
    level <= -20'sd40000;
    wr(4'h0, 16'h14e0);
    chk("old mux", 32'h1, 32'(mux_neg));
    wait_sig(0, 1'b0);
    rd(4'h4, d);
    chk("neg clamp", 32'h8000, d);
    chk("new mux", 32'h3, 32'(mux_neg));
    wr(4'h0, 16'h15e0);
    chk("finishing", 32'h1, 32'(conv_busy));
    wait_sig(1, 1'b0);
    repeat (5) @(posedge clk_sys);
    rd(4'h8, d);
    chk("status", 32'h4, d);
    wr(4'h0, 16'h04e0);
    wait_sig(1, 1'b1);
    wait_sig(0, 1'b1);
    wait_sig(0, 1'b0);
    chk("ready lead", 32'h1, 32'(n >= 6 && n <= 8));
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(4'h0, d);
    chk("cfg rereset", 32'h580, d);
    chk("power rereset", 32'h0, 32'(modulator_on));
    end_of_test();
  end
endmodule
bind adc_conversion_sequencer seq_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) seq_monitor_i (
  .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mux_neg(mux_neg), .mux_neg_gnd(mux_neg_gnd),
  .modulator_on(modulator_on), .filter_restart(filter_restart),
  .serial_out_ready(serial_out_ready), .conv_busy(conv_busy));
